/* File: otm_pkg.sv */
package otm_pkg;
    // command codes
    localparam logic [7:0] OTM_CMD_FAULT_THR = 8'h4f;
    localparam logic [7:0] OTM_CMD_FAULT_ACT = 8'h50;
    localparam logic [7:0] OTM_CMD_WARN_THR = 8'h51;
    localparam logic [7:0] OTM_CMD_STATUS = 8'h7d;

    // field positions
    localparam int OTM_SEL_LSB = 0;
    localparam int OTM_SEL_W = 3;
    localparam int OTM_RESTART_BIT = 3;
    localparam int OTM_STAT_FAULT_BIT = 7;
    localparam int OTM_STAT_WARN_BIT = 6;

    // values held until the nonvolatile load arrives
    localparam logic [2:0] OTM_FAULT_SEL_RST = 3'h0;
    localparam logic OTM_RESTART_RST = 1'b0;
    localparam logic [2:0] OTM_WARN_SEL_RST = 3'h0;

    // fault threshold ladder, degrees C
    localparam logic [7:0] OTM_FAULT_BASE_C = 8'h73;
    localparam logic [7:0] OTM_FAULT_STEP_C = 8'h05;

    // warning thresholds, degrees C
    localparam logic [7:0] OTM_WARN_C0 = 8'h55;
    localparam logic [7:0] OTM_WARN_C1 = 8'h5f;
    localparam logic [7:0] OTM_WARN_C2 = 8'h64;
    localparam logic [7:0] OTM_WARN_C3 = 8'h69;
    localparam logic [7:0] OTM_WARN_C4 = 8'h73;
    localparam logic [7:0] OTM_WARN_C5 = 8'h6e;
    localparam logic [7:0] OTM_WARN_C6 = 8'h7d;
    localparam logic [7:0] OTM_WARN_C7 = 8'h87;

    // timing
    localparam int OTM_CLK_HZ = 40000000;
    localparam int OTM_RESTART_MS = 56;
    localparam int OTM_RESTART_CYCLES = OTM_RESTART_MS * (OTM_CLK_HZ / 1000);

    typedef enum logic [1:0] {
        OTM_ST_OFF,
        OTM_ST_RUN,
        OTM_ST_LATCHED,
        OTM_ST_WAIT
    } otm_state_t;
endpackage : otm_pkg

/* File: otm_restart_timer.sv */
`timescale 1ns/100ps
`default_nettype none
module otm_restart_timer
    import otm_pkg::*;
#(
    parameter int CYCLES = OTM_RESTART_CYCLES
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    // control
    input wire logic start_i,
    output logic done_o
);
    localparam int CW = $clog2(CYCLES + 1);

    initial begin
        if (CYCLES < 1) begin
            $error("otm_restart_timer: CYCLES must be at least 1");
        end
    end

    logic [CW-1:0] cnt_q;
    logic busy_q;

    // a fresh start while busy reloads the count
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_q <= '0;
            busy_q <= 1'b0;
        end else if (start_i) begin
            cnt_q <= CW'(CYCLES - 1);
            busy_q <= 1'b1;
        end else if (busy_q) begin
            if (cnt_q == '0) begin
                busy_q <= 1'b0;
            end else begin
                cnt_q <= cnt_q - CW'(1);
            end
        end
    end

    assign done_o = busy_q && (cnt_q == '0);
endmodule : otm_restart_timer
`default_nettype wire

/* File: otm_monitor.sv */
// Contract
// - fault threshold select in bits 2:0, 115 to 150 C in 5 C steps.
// - fault detected by comparing temperature telemetry against selected fault threshold.
// - on fault act per restart bit and set the fault flag in status.
// - restart bit 0 latches off until power cycle or enable toggle.
// - restart bit 1 restarts 56 ms after each fault, unlimited attempts.
// - warning select decodes to 85,95,100,105,115,-,125,135 C; the code decodes select 5 to 110 C.
// - warning detected by comparing telemetry against selected warning threshold.
// - warning sets the warning flag in status with no shutdown.
// - reserved bits read zero and ignore writes.
// - registers at 4Fh, 50h, 51h by byte access; defaults from nonvolatile load.
// - no alert output; events are seen only by reading status.
`timescale 1ns/100ps
`default_nettype none
module otm_monitor
    import otm_pkg::*;
#(
    parameter int RESTART_CYCLES = OTM_RESTART_CYCLES
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    // command port, one byte per transaction
    input wire logic [7:0] cmd_i,
    input wire logic wr_i,
    input wire logic [7:0] wdata_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    output logic rvalid_o,
    // nonvolatile defaults
    input wire logic nvm_load_i,
    input wire logic [2:0] nvm_fault_sel_i,
    input wire logic nvm_restart_i,
    input wire logic [2:0] nvm_warn_sel_i,
    // telemetry and power stage
    input wire logic [7:0] temp_i,
    input wire logic enable_i,
    output logic convert_en_o
);
    initial begin
        if (RESTART_CYCLES < 1) begin
            $error("otm_monitor: RESTART_CYCLES must be at least 1");
        end
    end

    function automatic logic [7:0] fault_limit(input logic [2:0] sel);
        fault_limit = OTM_FAULT_BASE_C + 8'(OTM_FAULT_STEP_C * sel);
    endfunction : fault_limit

    function automatic logic [7:0] warn_limit(input logic [2:0] sel);
        case (sel)
            3'h0: warn_limit = OTM_WARN_C0;
            3'h1: warn_limit = OTM_WARN_C1;
            3'h2: warn_limit = OTM_WARN_C2;
            3'h3: warn_limit = OTM_WARN_C3;
            3'h4: warn_limit = OTM_WARN_C4;
            3'h5: warn_limit = OTM_WARN_C5;
            3'h6: warn_limit = OTM_WARN_C6;
            default: warn_limit = OTM_WARN_C7;
        endcase
    endfunction : warn_limit

    logic [2:0] fault_temp_select_q;
    logic restart_sel_q;
    logic [2:0] warning_temp_select_q;
    logic fault_temp_flag_q;
    logic warning_temp_flag_q;
    logic en_meta_q;
    logic en_sync_q;
    otm_state_t state_q;
    logic hot_fault;
    logic hot_warn;
    logic fault_event;
    logic restart_done;
    logic stat_wr;

    // enable pin crosses in from outside
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            en_meta_q <= 1'b0;
            en_sync_q <= 1'b0;
        end else begin
            en_meta_q <= enable_i;
            en_sync_q <= en_meta_q;
        end
    end

    // configuration: nonvolatile load, then host writes take effect at once
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            fault_temp_select_q <= OTM_FAULT_SEL_RST;
            restart_sel_q <= OTM_RESTART_RST;
            warning_temp_select_q <= OTM_WARN_SEL_RST;
        end else if (nvm_load_i) begin
            fault_temp_select_q <= nvm_fault_sel_i;
            restart_sel_q <= nvm_restart_i;
            warning_temp_select_q <= nvm_warn_sel_i;
        end else if (wr_i) begin
            case (cmd_i)
                OTM_CMD_FAULT_THR: fault_temp_select_q <= wdata_i[OTM_SEL_LSB +: OTM_SEL_W];
                OTM_CMD_FAULT_ACT: restart_sel_q <= wdata_i[OTM_RESTART_BIT];
                OTM_CMD_WARN_THR: warning_temp_select_q <= wdata_i[OTM_SEL_LSB +: OTM_SEL_W];
                default: ;
            endcase
        end
    end

    assign hot_fault = temp_i >= fault_limit(fault_temp_select_q);
    assign hot_warn = temp_i >= warn_limit(warning_temp_select_q);
    // only a running converter can trip; every restart re-arms the check, even while still hot
    assign fault_event = (state_q == OTM_ST_RUN) && hot_fault;
    assign stat_wr = wr_i && (cmd_i == OTM_CMD_STATUS);

    // status flags: write one to clear, a new event wins over the clear
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            fault_temp_flag_q <= 1'b0;
            warning_temp_flag_q <= 1'b0;
        end else begin
            if (fault_event) begin
                fault_temp_flag_q <= 1'b1;
            end else if (stat_wr && wdata_i[OTM_STAT_FAULT_BIT]) begin
                fault_temp_flag_q <= 1'b0;
            end
            if (hot_warn) begin
                warning_temp_flag_q <= 1'b1;
            end else if (stat_wr && wdata_i[OTM_STAT_WARN_BIT]) begin
                warning_temp_flag_q <= 1'b0;
            end
        end
    end

    otm_restart_timer #(
        .CYCLES(RESTART_CYCLES)
    ) u_restart_timer (
        .clk_sys_i(clk_sys_i),
        .rstn_i(rstn_i),
        .start_i(fault_event && restart_sel_q),
        .done_o(restart_done)
    );

    // conversion control; enable low always wins and clears a latch-off
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_q <= OTM_ST_OFF;
        end else if (!en_sync_q) begin
            state_q <= OTM_ST_OFF;
        end else begin
            case (state_q)
                OTM_ST_OFF: state_q <= OTM_ST_RUN;
                OTM_ST_RUN: begin
                    if (hot_fault) begin
                        state_q <= restart_sel_q ? OTM_ST_WAIT : OTM_ST_LATCHED;
                    end
                end
                OTM_ST_LATCHED: state_q <= OTM_ST_LATCHED;
                OTM_ST_WAIT: begin
                    if (restart_done) begin
                        state_q <= OTM_ST_RUN;
                    end
                end
                default: state_q <= OTM_ST_OFF;
            endcase
        end
    end

    // warnings never reach this output; no alert pin exists
    assign convert_en_o = (state_q == OTM_ST_RUN);

    // read port answers one cycle after the strobe
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_o <= 8'h00;
            rvalid_o <= 1'b0;
        end else begin
            rvalid_o <= rd_i;
            if (rd_i) begin
                rdata_o <= 8'h00;
                case (cmd_i)
                    OTM_CMD_FAULT_THR: rdata_o[OTM_SEL_LSB +: OTM_SEL_W] <= fault_temp_select_q;
                    OTM_CMD_FAULT_ACT: rdata_o[OTM_RESTART_BIT] <= restart_sel_q;
                    OTM_CMD_WARN_THR: rdata_o[OTM_SEL_LSB +: OTM_SEL_W] <= warning_temp_select_q;
                    OTM_CMD_STATUS: begin
                        rdata_o[OTM_STAT_FAULT_BIT] <= fault_temp_flag_q;
                        rdata_o[OTM_STAT_WARN_BIT] <= warning_temp_flag_q;
                    end
                    default: ;
                endcase
            end
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);

    sequence s_trip;
        en_sync_q && (state_q == OTM_ST_RUN) && hot_fault;
    endsequence

    sequence s_restart_wait;
        (state_q == OTM_ST_WAIT) && !convert_en_o;
    endsequence

    a_fault_flag_set: assert property (s_trip |=> fault_temp_flag_q)
        else $error("fault flag not set after trip");
    a_latch_off: assert property ((s_trip and !restart_sel_q) |=> (state_q == OTM_ST_LATCHED) && !convert_en_o)
        else $error("latch-off not taken");
    a_latch_holds: assert property ((state_q == OTM_ST_LATCHED) && en_sync_q |=> !convert_en_o)
        else $error("latched converter restarted without enable toggle");
    a_auto_restart: assert property ((s_trip and restart_sel_q) |=> s_restart_wait ##1 !convert_en_o)
        else $error("restart wait not entered");
    a_restart_end: assert property ((state_q == OTM_ST_WAIT) && restart_done && en_sync_q
        |=> convert_en_o)
        else $error("restart not taken at timer end");
    a_warn_flag: assert property (hot_warn |=> warning_temp_flag_q)
        else $error("warning flag not set");
    a_warn_no_stop: assert property (convert_en_o && hot_warn && !hot_fault && en_sync_q
        |=> convert_en_o)
        else $error("warning shut conversion down");
    a_set_wins: assert property (fault_event && stat_wr |=> fault_temp_flag_q)
        else $error("clear beat a new fault");
    a_write_applies: assert property (wr_i && !nvm_load_i && (cmd_i == OTM_CMD_FAULT_THR)
        |=> fault_temp_select_q == $past(wdata_i[2:0]))
        else $error("fault threshold write not applied");
    a_reserved_zero: assert property (rd_i && (cmd_i == OTM_CMD_FAULT_ACT)
        |=> rvalid_o && (rdata_o[7:4] == 4'h0) && (rdata_o[2:0] == 3'h0))
        else $error("reserved bits read nonzero");
    a_fault_compare: assert property ((state_q == OTM_ST_RUN) && en_sync_q
        && (temp_i >= OTM_FAULT_BASE_C + 8'(OTM_FAULT_STEP_C * fault_temp_select_q))
        |=> !convert_en_o)
        else $error("fault threshold not honoured");
endmodule : otm_monitor
`default_nettype wire

/* File: otm_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module otm_host_model (
    // clock
    input wire logic clk_sys_i,
    // command port
    output logic [7:0] cmd_o,
    output logic wr_o,
    output logic [7:0] wdata_o,
    output logic rd_o,
    input wire logic [7:0] rdata_i,
    input wire logic rvalid_i
);
    initial begin
        cmd_o = 8'h00;
        wr_o = 1'b0;
        wdata_o = 8'h00;
        rd_o = 1'b0;
    end
    // single byte write, one sampling edge
    task automatic write_byte(input logic [7:0] cmd, input logic [7:0] data);
        @(posedge clk_sys_i);
        #1;
        cmd_o = cmd;
        wdata_o = data;
        wr_o = 1'b1;
        @(posedge clk_sys_i);
        #1;
        wr_o = 1'b0;
        // released lines must not keep looking valid
        cmd_o = ~cmd;
        wdata_o = ~data;
    endtask : write_byte
    task automatic read_byte(input logic [7:0] cmd, output logic [7:0] data, output logic ok);
        @(posedge clk_sys_i);
        #1;
        cmd_o = cmd;
        rd_o = 1'b1;
        @(posedge clk_sys_i);
        #1;
        rd_o = 1'b0;
        ok = rvalid_i;
        data = rdata_i;
        cmd_o = ~cmd;
    endtask : read_byte
endmodule : otm_host_model
`default_nettype wire

/* File: tb_otm_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_otm_monitor
    import otm_pkg::*;
;
    // short restart delay keeps the run brief
    localparam int RST_CYC = 20;
    logic clk_sys_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [7:0] cmd, wdata, rdata;
    logic wr, rd, rvalid, conv_en;
    logic [7:0] temp = 8'h00;
    logic enable = 1'b1;
    logic nvm_load = 1'b0;
    logic nvm_restart = 1'b0;
    logic [2:0] nvm_fault_sel = 3'h0;
    logic [2:0] nvm_warn_sel = 3'h0;
    logic [7:0] warn_c [8] = '{8'h55, 8'h5f, 8'h64, 8'h69, 8'h73, 8'h6e, 8'h7d, 8'h87};
    int err_count = 0;
    int num_checks = 0;
    always #12.5 clk_sys_i = ~clk_sys_i;
    otm_monitor #(.RESTART_CYCLES(RST_CYC)) dut_u (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .cmd_i(cmd),
        .wr_i(wr), .wdata_i(wdata), .rd_i(rd), .rdata_o(rdata), .rvalid_o(rvalid), .nvm_load_i(nvm_load),
        .nvm_fault_sel_i(nvm_fault_sel), .nvm_restart_i(nvm_restart), .nvm_warn_sel_i(nvm_warn_sel),
        .temp_i(temp), .enable_i(enable), .convert_en_o(conv_en));
    otm_host_model host_u (.clk_sys_i(clk_sys_i), .cmd_o(cmd), .wr_o(wr), .wdata_o(wdata), .rd_o(rd),
        .rdata_i(rdata), .rvalid_i(rvalid));
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask : step
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk8
    task automatic chk1(input logic got, input logic exp, input string what);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: %s got %b", $time, what, got);
        end
    endtask : chk1
    task automatic rd_chk(input logic [7:0] c, input logic [7:0] exp);
        logic [7:0] d;
        logic ok;
        host_u.read_byte(c, d, ok);
        chk1(ok, 1'b1, "rvalid");
        chk8(d, exp, "rdata");
    endtask : rd_chk
    task automatic wait_conv(input logic v, input int lim, output int n);
        n = 0;
        while (conv_en !== v && n < lim) begin
            step(1);
            n++;
        end
    endtask : wait_conv
    task automatic t_regs();
        logic [7:0] c [4] = '{OTM_CMD_FAULT_THR, OTM_CMD_FAULT_ACT, OTM_CMD_WARN_THR, 8'h52};
        logic [7:0] m [4] = '{8'h07, 8'h08, 8'h07, 8'h00};
        for (int i = 0; i < 4; i++) begin
            rd_chk(c[i], 8'h00);
            host_u.write_byte(c[i], 8'hff);
            rd_chk(c[i], m[i]);
        end
        rd_chk(OTM_CMD_STATUS, 8'h00);
    endtask : t_regs
    task automatic t_nvm();
        nvm_fault_sel = 3'h5;
        nvm_warn_sel = 3'h2;
        nvm_load = 1'b1;
        step(1);
        nvm_load = 1'b0;
        rd_chk(OTM_CMD_FAULT_THR, 8'h05);
        rd_chk(OTM_CMD_FAULT_ACT, 8'h00);
        rd_chk(OTM_CMD_WARN_THR, 8'h02);
    endtask : t_nvm
    task automatic t_fault();
        for (int c = 0; c < 8; c++) begin
            host_u.write_byte(OTM_CMD_FAULT_THR, 8'(c));
            temp = 8'h72 + 8'(5 * c);
            step(3);
            chk1(conv_en, 1'b1, "below");
            temp = temp + 8'h01;
            step(2);
            chk1(conv_en, 1'b0, "trip");
            step(10);
            chk1(conv_en, 1'b0, "latched");
            rd_chk(OTM_CMD_STATUS, 8'hc0);
            temp = 8'h00;
            enable = 1'b0;
            step(4);
            enable = 1'b1;
            step(6);
            chk1(conv_en, 1'b1, "toggle");
            host_u.write_byte(OTM_CMD_STATUS, 8'hc0);
            rd_chk(OTM_CMD_STATUS, 8'h00);
        end
    endtask : t_fault
    task automatic t_warn();
        host_u.write_byte(OTM_CMD_FAULT_THR, 8'h07);
        for (int c = 0; c < 8; c++) begin
            temp = 8'h00;
            host_u.write_byte(OTM_CMD_WARN_THR, 8'(c));
            temp = warn_c[c] - 8'h01;
            step(2);
            host_u.write_byte(OTM_CMD_STATUS, 8'hc0);
            rd_chk(OTM_CMD_STATUS, 8'h00);
            temp = warn_c[c];
            step(2);
            rd_chk(OTM_CMD_STATUS, 8'h40);
            chk1(conv_en, 1'b1, "no shutdown");
        end
    endtask : t_warn
    task automatic t_restart();
        int n;
        temp = 8'h00;
        nvm_restart = 1'b1;
        nvm_fault_sel = 3'h0;
        nvm_warn_sel = 3'h7;
        nvm_load = 1'b1;
        step(1);
        nvm_load = 1'b0;
        rd_chk(OTM_CMD_FAULT_ACT, 8'h08);
        host_u.write_byte(OTM_CMD_FAULT_ACT, 8'h08);
        host_u.write_byte(OTM_CMD_FAULT_THR, 8'h00);
        host_u.write_byte(OTM_CMD_STATUS, 8'hff);
        temp = 8'h73;
        // still hot after each restart, so it must trip again every time
        for (int k = 0; k < 2; k++) begin
            wait_conv(1'b0, 5, n);
            chk1(conv_en, 1'b0, "trip");
            wait_conv(1'b1, 100, n);
            chk1(n == RST_CYC, 1'b1, "delay");
        end
        temp = 8'h00;
        step(RST_CYC + 5);
        chk1(conv_en, 1'b1, "cool run");
        rd_chk(OTM_CMD_STATUS, 8'h80);
    endtask : t_restart
    task automatic test_done();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : test_done
    initial begin
        repeat (6) @(posedge clk_sys_i);
        #1;
        rstn_i = 1'b1;
        step(6);
        t_regs();
        t_nvm();
        t_fault();
        t_warn();
        t_restart();
        test_done();
    end
    initial begin
        #(25 * 60000);
        err_count++;
        $display("unexpected at %0t: timeout", $time);
        test_done();
    end
endmodule : tb_otm_monitor
`default_nettype wire
